// ==== adc_converter_port.sv ====
// Converter end: pipelined sample path, coding, scrambling, output drive.
// Assumes sample clock arrives as a pin from the capture side.
//
// Contract
// - Falling sample clock edge starts each conversion.
// - Receiver may capture on rising clock edge.
// - Result appears seven sample cycles after sampling.
// - Power-down high floats outputs, halts analog.
// - Dither added only while dither pin high.
// - Sixteen-bit word, bit fifteen is MSB.
// - Negative strobe toggles per sample; capture falling.
// - Positive strobe is complement; capture rising.
// - Overflow flag high on over/underflow.
// - Output enable low drives, high floats.
// - Format pin selects coding and duty correction.
// - Scramble: bits one-fifteen XOR bit zero.
// - Receiver XORs LSB back into other bits.
// - Gain pin selects front-end gain and range.
`timescale 1ns/10ps
module adc_converter_port
	import adc_port_pkg::*;
#(
	parameter int LATENCY = PIPE_LATENCY
) (
	input  wire logic                   clk_i,
	input  wire logic                   reset_n_i,
	adc_port_if.converter               port,
	input  wire logic [WORD_WIDTH-1:0]  analog_code_i,
	input  wire logic                   analog_over_i,
	input  wire logic                   analog_under_i,
	input  wire logic                   power_down_pin_i,
	input  wire logic                   dither_enable_pin_i,
	input  wire logic                   output_enable_n_i,
	input  wire adc_port_pkg::format_mode_type mode_pin_i,
	input  wire logic                   scramble_select_pin_i,
	input  wire logic                   gain_select_pin_i,
	output logic                        duty_stabilizer_o,
	output logic                        gain_high_o
);
	import adc_port_pkg::*;

	// Refuse pipeline depths the shift chain is not sized for
	if (LATENCY < 1 || LATENCY > 32) begin : g_latency_check
		$error("LATENCY out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// Not reset: reset lasts long enough to flush them
	logic [1:0] clk_sync;
	logic [1:0] pd_sync;
	logic [1:0] dither_sync;
	logic [1:0] oe_sync;
	logic [1:0] scramble_sync;
	logic [1:0] gain_sync;
	logic [1:0] mode0_sync;
	logic [1:0] mode1_sync;
	logic       clk_prev;

	always_ff @(posedge clk_i) begin
		clk_sync      <= {clk_sync[0], port.sample_clk};
		pd_sync       <= {pd_sync[0], power_down_pin_i};
		dither_sync   <= {dither_sync[0], dither_enable_pin_i};
		oe_sync       <= {oe_sync[0], output_enable_n_i};
		scramble_sync <= {scramble_sync[0], scramble_select_pin_i};
		gain_sync     <= {gain_sync[0], gain_select_pin_i};
		mode0_sync    <= {mode0_sync[0], mode_pin_i[0]};
		mode1_sync    <= {mode1_sync[0], mode_pin_i[1]};
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			clk_prev <= 1'b0;
		else
			clk_prev <= clk_sync[1];
	end

	logic            sample_fall;
	logic            sample_rise;
	format_mode_type mode;
	assign sample_fall = clk_prev & ~clk_sync[1];
	assign sample_rise = ~clk_prev & clk_sync[1];
	assign mode        = format_mode_type'({mode1_sync[1], mode0_sync[1]});

	////////////////////////////////////////////////////////////////////////
	// Static controls
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			duty_stabilizer_o <= 1'b0;
			gain_high_o       <= 1'b0;
		end else begin
			duty_stabilizer_o <= (mode == mode_ob_dcs_on) || (mode == mode_tc_dcs_on);
			gain_high_o       <= gain_sync[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample, dither and pipeline
	logic [WORD_WIDTH-1:0] dither_lfsr;
	logic [WORD_WIDTH-1:0] pipe_word [LATENCY];
	logic                  pipe_ovf  [LATENCY];

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			dither_lfsr <= 16'h0001;
		else if (sample_fall)
			dither_lfsr <= {dither_lfsr[14:0],
				dither_lfsr[15] ^ dither_lfsr[13] ^ dither_lfsr[12] ^ dither_lfsr[10]};
	end

	// Dither nudges the code by one step, never past full scale
	function automatic logic [WORD_WIDTH-1:0] add_dither(
		input logic [WORD_WIDTH-1:0] code,
		input logic                  en,
		input logic                  bit_in
	);
		logic [WORD_WIDTH-1:0] res;
		res = code;
		if (en && bit_in && code != CODE_MAX)
			res = code + 16'h0001;
		return res;
	endfunction

	logic [WORD_WIDTH-1:0] held_code;
	logic                  held_ovf;
	always_comb begin
		held_code = add_dither(analog_code_i, dither_sync[1], dither_lfsr[0]);
		held_ovf  = analog_over_i | analog_under_i;
		if (analog_over_i)
			held_code = CODE_MAX;
		else if (analog_under_i)
			held_code = CODE_MIN;
	end

	// Power-down freezes the chain; its depth sets the latency
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < LATENCY; i++) begin
				pipe_word[i] <= CODE_MIN;
				pipe_ovf[i]  <= 1'b0;
			end
		end else if (sample_fall && !pd_sync[1]) begin
			pipe_word[0] <= held_code;
			pipe_ovf[0]  <= held_ovf;
			for (int i = 1; i < LATENCY; i++) begin
				pipe_word[i] <= pipe_word[i-1];
				pipe_ovf[i]  <= pipe_ovf[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Coding, scrambling and output registers
	function automatic logic [WORD_WIDTH-1:0] scramble(
		input logic [WORD_WIDTH-1:0] w,
		input logic                  en
	);
		logic [WORD_WIDTH-1:0] res;
		res = w;
		if (en)
			res[MSB_POS:1] = w[MSB_POS:1] ^ {MSB_POS{w[LSB_POS]}};
		return res;
	endfunction

	logic                  twos_comp;
	logic [WORD_WIDTH-1:0] coded_word;
	assign twos_comp  = (mode == mode_tc_dcs_on) || (mode == mode_tc_dcs_off);
	assign coded_word = twos_comp ? (pipe_word[LATENCY-1] ^ MSB_MASK)
	                              : pipe_word[LATENCY-1];

	logic [WORD_WIDTH-1:0] out_word;
	logic                  out_ovf;
	logic                  strobe_neg;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			out_word <= CODE_MIN;
			out_ovf  <= 1'b0;
		end else if (sample_fall && !pd_sync[1]) begin
			out_word <= scramble(coded_word, scramble_sync[1]);
			out_ovf  <= pipe_ovf[LATENCY-1];
		end
	end

	// Strobe falls half a sample after the word changes, mid-eye
	// Idles high so the receiver sees no false edge after reset
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			strobe_neg <= 1'b1;
		else if (sample_fall)
			strobe_neg <= 1'b1;
		else if (sample_rise)
			strobe_neg <= 1'b0;
	end

	// Outputs float while disabled or powered down
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			port.drive_en <= 1'b0;
		else
			port.drive_en <= ~oe_sync[1] & ~pd_sync[1];
	end

	assign port.sample_word_bits      = out_word;
	assign port.range_overflow_flag   = out_ovf;
	assign port.valid_strobe_negative = strobe_neg;
	assign port.valid_strobe_positive = ~strobe_neg;
endmodule

// ==== adc_port_pkg.sv ====
// Constants shared by the converter output port and its capture logic.
// Assumes both ends sit on one 10 MHz system clock.
package adc_port_pkg;
	localparam int          WORD_WIDTH       = 16;
	localparam int          MSB_POS          = 15;
	localparam int          LSB_POS          = 0;
	localparam int          PIPE_LATENCY     = 7;
	localparam int          CLK_PERIOD_NS    = 100;
	localparam int          SAMPLE_PERIOD_NS = 800;
	localparam int          SAMPLE_DIV       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] CODE_MAX         = 16'hFFFF;
	localparam logic [15:0] CODE_MIN         = 16'h0000;
	localparam logic [15:0] MSB_MASK         = 16'h8000;

	typedef enum logic [1:0] {
		mode_ob_dcs_off  = 2'b00,
		mode_ob_dcs_on   = 2'b01,
		mode_tc_dcs_on   = 2'b10,
		mode_tc_dcs_off  = 2'b11
	} format_mode_type;

	// Register map of the capture logic
	localparam logic [3:0] ADDR_DATA   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK   = 4'h2;
	localparam logic [3:0] ADDR_CTRL   = 4'h3;
	localparam int         ST_SAMPLE   = 0;
	localparam int         ST_OVF      = 1;
	localparam int         CTRL_DESCR  = 0;
endpackage

// ==== adc_port_if.sv ====
// Parallel output pins between converter and capture logic.
// Assumes the bench resolves driven values from the enable.
`timescale 1ns/10ps
interface adc_port_if;
	logic        sample_clk;
	logic [15:0] sample_word_bits;
	logic        range_overflow_flag;
	logic        valid_strobe_negative;
	logic        valid_strobe_positive;
	logic        drive_en;

	modport converter (
		input  sample_clk,
		output sample_word_bits,
		output range_overflow_flag,
		output valid_strobe_negative,
		output valid_strobe_positive,
		output drive_en
	);
	modport capture (
		output sample_clk,
		input  sample_word_bits,
		input  range_overflow_flag,
		input  valid_strobe_negative,
		input  valid_strobe_positive,
		input  drive_en
	);
endinterface

// ==== adc_capture_port.sv ====
// Capture end: makes the sample clock, latches words, register port.
// Assumes a plain register master on the system clock.
`timescale 1ns/10ps
module adc_capture_port
	import adc_port_pkg::*;
#(
	parameter int DIV = SAMPLE_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	adc_port_if.capture      port,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o
);
	import adc_port_pkg::*;

	if (DIV < 2 || DIV > 256 || DIV % 2 != 0) begin : g_div_check
		$error("DIV must be even, 2..256");
	end

	////////////////////////////////////////////////////////////////////////
	// Sample clock divider
	logic [7:0] div_cnt;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			div_cnt         <= 8'h00;
			port.sample_clk <= 1'b0;
		end else if (div_cnt == 8'(DIV / 2 - 1)) begin
			div_cnt         <= 8'h00;
			port.sample_clk <= ~port.sample_clk;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and capture on strobe falling edge
	logic [1:0]  strobe_sync;
	logic [15:0] word_s1;
	logic [15:0] word_s2;
	logic [1:0]  ovf_sync;
	logic [1:0]  en_sync;
	logic        strobe_prev;
	always_ff @(posedge clk_i) begin
		strobe_sync <= {strobe_sync[0], port.valid_strobe_negative};
		word_s1     <= port.sample_word_bits;
		word_s2     <= word_s1;
		ovf_sync    <= {ovf_sync[0], port.range_overflow_flag};
		en_sync     <= {en_sync[0], port.drive_en};
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			strobe_prev <= 1'b1;
		else
			strobe_prev <= strobe_sync[1];
	end

	logic capture;
	assign capture = strobe_prev & ~strobe_sync[1] & en_sync[1];

	logic        descramble_en;
	logic [15:0] data_reg;
	logic        ovf_reg;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			data_reg <= CODE_MIN;
			ovf_reg  <= 1'b0;
		end else if (capture) begin
			data_reg <= descramble_en ?
				{word_s2[MSB_POS:1] ^ {MSB_POS{word_s2[LSB_POS]}}, word_s2[LSB_POS]}
				: word_s2;
			ovf_reg  <= ovf_sync[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and interrupt
	logic [1:0] status;
	logic [1:0] mask;
	logic [1:0] events;
	assign events = {capture & ovf_sync[1], capture};

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			status <= 2'b00;
		else if (wr_i && addr_i == ADDR_STATUS)
			status <= (status & ~wdata_i[1:0]) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mask          <= 2'b00;
			descramble_en <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == ADDR_MASK)
				mask <= wdata_i[1:0];
			if (addr_i == ADDR_CTRL)
				descramble_en <= wdata_i[CTRL_DESCR];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i) begin
			case (addr_i)
				ADDR_DATA:   rdata_o <= {15'h0000, ovf_reg, data_reg};
				ADDR_STATUS: rdata_o <= {30'h0000_0000, status};
				ADDR_MASK:   rdata_o <= {30'h0000_0000, mask};
				ADDR_CTRL:   rdata_o <= {31'h0000_0000, descramble_en};
				default:     rdata_o <= 32'h0000_0000;
			endcase
		end else
			rdata_o <= 32'h0000_0000;
	end

	assign irq_o = |(status & mask);
endmodule

// ==== adc_port_monitor.sv ====
// Assertions on the converter-to-capture pins.
// Assumes the bench wires it beside the pin interface.
`timescale 1ns/10ps
module adc_port_monitor #(
	parameter int DIV = 8
) (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        sample_clk,
	input wire logic [15:0] sample_word_bits,
	input wire logic        range_overflow_flag,
	input wire logic        valid_strobe_negative,
	input wire logic        valid_strobe_positive,
	input wire logic        drive_en
);
	logic sck_q;
	logic armed;
	int   gap;
	wire  vneg = valid_strobe_negative;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i || !drive_en);
	// Counts cycles since the last sample clock fall
	always_ff @(posedge clk_i) begin
		sck_q <= sample_clk;
		armed <= reset_n_i && (armed || (sck_q && !sample_clk));
		gap   <= (sck_q && !sample_clk) ? 0 : gap + 1;
	end
	////////////////////////////////////////////////////////////
	property p_period; armed && sck_q && !sample_clk |-> gap == DIV - 1; endproperty
	a_period: assert property (p_period) else $error("bad clock period");
	property p_take; $fell(sample_clk) |-> ##[1:6] $rose(vneg); endproperty
	a_take: assert property (p_take) else $error("no word after clock fall");
	property p_fall; $rose(sample_clk) |-> ##[1:6] $fell(vneg); endproperty
	a_fall: assert property (p_fall) else $error("strobe not lowered");
	property p_high; $rose(vneg) |-> vneg[*4] ##1 !vneg; endproperty
	a_high: assert property (p_high) else $error("strobe high time wrong");
	property p_step; $rose(vneg) |-> ##8 $rose(vneg); endproperty
	a_step: assert property (p_step) else $error("strobe not at sample rate");
	property p_pair; valid_strobe_positive == !vneg; endproperty
	a_pair: assert property (p_pair) else $error("strobes not complementary");
	property p_word; !$rose(vneg) |-> $stable(sample_word_bits); endproperty
	a_word: assert property (p_word) else $error("word moved off strobe");
	property p_flag; !$rose(vneg) |-> $stable(range_overflow_flag); endproperty
	a_flag: assert property (p_flag) else $error("flag moved off strobe");
	property p_rise; $changed(sample_word_bits) |-> !sample_clk; endproperty
	a_rise: assert property (p_rise) else $error("word moved while clock high");
endmodule

// ==== tb.sv ====
// Bench: converter and capture ends joined over the pin interface.
// Assumes the default sample divider and a 100 ns system clock.
`timescale 1ns/10ps
module tb;
	import adc_port_pkg::*;
	logic            clk_i;
	logic            reset_n_i;
	logic [15:0]     code;
	logic            over, under, pd, dither, oe_n, scr, gain, wr, rd;
	format_mode_type mode;
	logic [3:0]      addr;
	logic [31:0]     wdata, rdata, d;
	logic            irq, dcs, gain_o;
	int              error_cnt, check_count;
	adc_port_if bus ();
	adc_converter_port adc_converter_port_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .port(bus),
		.analog_code_i(code), .analog_over_i(over), .analog_under_i(under),
		.power_down_pin_i(pd), .dither_enable_pin_i(dither), .output_enable_n_i(oe_n),
		.mode_pin_i(mode), .scramble_select_pin_i(scr), .gain_select_pin_i(gain),
		.duty_stabilizer_o(dcs), .gain_high_o(gain_o));
	adc_capture_port #(.DIV(SAMPLE_DIV)) adc_capture_port_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .port(bus), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .irq_o(irq));
	adc_port_monitor #(.DIV(SAMPLE_DIV)) adc_port_monitor_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .sample_clk(bus.sample_clk),
		.sample_word_bits(bus.sample_word_bits), .range_overflow_flag(bus.range_overflow_flag),
		.valid_strobe_negative(bus.valid_strobe_negative),
		.valid_strobe_positive(bus.valid_strobe_positive), .drive_en(bus.drive_en));
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wrr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Waits for n rises of the negative valid strobe
	task automatic rise(input int n);
		logic p;
		int   k;
		repeat (n) begin
			p = bus.valid_strobe_negative;
			for (k = 0; k < 20 && !(bus.valid_strobe_negative && !p); k++) begin
				p = bus.valid_strobe_negative;
				@(posedge clk_i);
				#1;
			end
			if (k == 20) begin
				error_cnt++;
				end_of_test();
			end
		end
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_latency;
		int n;
		rise(1);
		@(posedge clk_i);
		code <= 16'hA5C3;
		for (n = 0; n < 12 && bus.sample_word_bits !== 16'hA5C3; n++)
			rise(1);
		chk("latency", n, PIPE_LATENCY + 1);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i);
			mode <= format_mode_type'(m);
			rise(PIPE_LATENCY + 2);
			rdr(ADDR_DATA);
			chk("word", d, {16'h0, m[1] ? 16'hA5C3 ^ MSB_MASK : 16'hA5C3});
			chk("duty", dcs, m == 1 || m == 2);
		end
		$display("latency and modes done");
	endtask
	task automatic t_range;
		wrr(ADDR_STATUS, 32'h3);
		wrr(ADDR_MASK, 32'h2);
		@(posedge clk_i);
		mode <= mode_ob_dcs_off;
		over <= 1'b1;
		rise(1);
		chk("irq idle", irq, 0);
		rise(PIPE_LATENCY + 1);
		chk("full", {bus.range_overflow_flag, bus.sample_word_bits}, {1'b1, CODE_MAX});
		chk("irq", irq, 1);
		@(posedge clk_i);
		over  <= 1'b0;
		under <= 1'b1;
		rise(PIPE_LATENCY + 2);
		rdr(ADDR_DATA);
		chk("zero", d, {15'h0, 1'b1, CODE_MIN});
		@(posedge clk_i);
		under <= 1'b0;
		rise(PIPE_LATENCY + 2);
		chk("flag low", bus.range_overflow_flag, 0);
		chk("irq held", irq, 1);
		wrr(ADDR_STATUS, 32'h2);
		rdr(ADDR_STATUS);
		chk("cleared", {d[1], irq}, 0);
		rdr(4'hF);
		chk("unmapped", d, 0);
		$display("range done");
	endtask
	task automatic t_scramble;
		@(posedge clk_i);
		scr  <= 1'b1;
		code <= 16'h1235;
		rise(PIPE_LATENCY + 2);
		chk("scrambled", bus.sample_word_bits, 16'h1235 ^ 16'hFFFE);
		wrr(ADDR_CTRL, 32'h1);
		rise(2);
		rdr(ADDR_DATA);
		chk("descrambled", d, 32'h1235);
		wrr(ADDR_CTRL, 32'h0);
		scr <= 1'b0;
		$display("scramble done");
	endtask
	task automatic t_pins;
		logic hit;
		hit = 1'b0;
		@(posedge clk_i);
		gain <= 1'b1;
		oe_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk("gain", gain_o, 1);
		chk("oe float", bus.drive_en, 0);
		@(posedge clk_i);
		oe_n <= 1'b0;
		pd   <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk("pd float", bus.drive_en, 0);
		@(posedge clk_i);
		pd   <= 1'b0;
		gain <= 1'b0;
		dither <= 1'b1;
		rise(PIPE_LATENCY + 2);
		chk("drive", bus.drive_en, 1);
		for (int k = 0; k < 16; k++) begin
			rise(1);
			chk("dither", bus.sample_word_bits inside {16'h1235, 16'h1236}, 1);
			hit |= bus.sample_word_bits == 16'h1236;
		end
		chk("dither seen", hit, 1);
		@(posedge clk_i);
		dither <= 1'b0;
		rise(PIPE_LATENCY + 2);
		chk("no dither", bus.sample_word_bits, 16'h1235);
		$display("pins done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		reset_n_i = 1'b0;
		code = 16'h0F0F;
		{over, under, pd, dither, oe_n, scr, gain, wr, rd} = '0;
		mode = mode_ob_dcs_off;
		addr = 4'h0;
		wdata = 32'h0;
		error_cnt = 0;
		check_count = 0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rise(PIPE_LATENCY + 2);
		t_latency();
		t_range();
		t_scramble();
		t_pins();
		end_of_test();
	end
endmodule
